/* asp_peer.sv */
// Remote serial peer of one port: 8N1 receiver and sender.
// Assumes a bit time of BT mclk cycles; the line idles high.
`timescale 1ns/1ns
module asp_peer #(
    parameter int BT = 16
)
(
    input  wire logic mclk,
    input  wire logic txd,
    output logic      rxd,
    output logic      cts_n
);
    logic [7:0] rx_byte;
    logic       got;
    initial
    begin
        rxd = 1'b1;
        cts_n = 1'b0;
        got = 1'b0;
        rx_byte = 8'h00;
    end
    // Sample each bit at its centre; the stop bit is waited out.
    always
    begin
        @(negedge txd);
        repeat (BT / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BT) @(posedge mclk);
            rx_byte[i] = txd;
        end
        got = 1'b1;
        repeat (BT) @(posedge mclk);
    end
    // Start low, data LSB first, one stop high.
    task automatic send(input logic [7:0] d);
        logic [9:0] fr;
        fr = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd <= fr[i];
            repeat (BT) @(posedge mclk);
        end
    endtask
endmodule

/* asp_pkg.sv */
// Shared constants and types for the dual asynchronous serial port.
// Assumes an APB master on a 50 MHz mclk and word-aligned 32-bit accesses.
package asp_pkg;

    // -------------------------------------------------------------------
    // Structure and timing
    // -------------------------------------------------------------------
    localparam int          ASP_NUM_PORTS   = 2;
    localparam int          ASP_FIFO_DEPTH  = 16;
    localparam int          ASP_DATA_W      = 8;
    localparam int          ASP_OVERSAMPLE  = 16;
    localparam int          ASP_MCLK_HZ     = 50000000;
    localparam int          ASP_MAX_BPS     = 3000000;
    // Largest divisor value that still reaches the top bit rate.
    localparam int          ASP_DIV_MIN     =
        ASP_MCLK_HZ / (ASP_OVERSAMPLE * ASP_MAX_BPS) - 1;
    localparam logic [15:0] ASP_BAUD_RST    = 16'h001a;

    // -------------------------------------------------------------------
    // Register map: bit 6 of the byte address selects the port.
    // -------------------------------------------------------------------
    localparam int          ASP_PORT_BIT    = 6;
    localparam logic [3:0]  ASP_R_DATA      = 4'h0;
    localparam logic [3:0]  ASP_R_CTRL      = 4'h1;
    localparam logic [3:0]  ASP_R_BAUD      = 4'h2;
    localparam logic [3:0]  ASP_R_LEVEL     = 4'h3;
    localparam logic [3:0]  ASP_R_STATUS    = 4'h4;
    localparam logic [3:0]  ASP_R_ISR       = 4'h5;
    localparam logic [3:0]  ASP_R_IEN       = 4'h6;
    localparam logic [3:0]  ASP_R_ICLR      = 4'h7;

    // Interrupt status bit positions.
    localparam int          ASP_I_RXLVL     = 0;
    localparam int          ASP_I_TXLVL     = 1;
    localparam int          ASP_I_EOT       = 2;
    localparam int          ASP_I_FRAME     = 3;
    localparam int          ASP_I_PARITY    = 4;
    localparam int          ASP_I_BREAK     = 5;
    localparam int          ASP_I_OVERRUN   = 6;
    localparam int          ASP_NUM_IRQ     = 7;

    // Parity modes.
    localparam logic [1:0]  ASP_PAR_NONE    = 2'h0;
    localparam logic [1:0]  ASP_PAR_EVEN    = 2'h1;
    localparam logic [1:0]  ASP_PAR_ODD     = 2'h2;
    localparam logic [1:0]  ASP_PAR_STICK   = 2'h3;

    // Control register layout, top bit first; enable is bit 0.
    typedef struct packed {
        logic       rts_flow;
        logic       cts_flow;
        logic       fifo_en;
        logic       send_break;
        logic       two_stop;
        logic       stick_val;
        logic [1:0] parity;
        logic [1:0] wlen;
        logic       enable;
    } asp_ctrl_t;
    localparam int          ASP_CTRL_W      = $bits(asp_ctrl_t);
    localparam asp_ctrl_t   ASP_CTRL_RST    = '{fifo_en: 1'b1, default: '0};

    typedef struct packed {
        logic [2:0] rx;
        logic [2:0] tx;
    } asp_level_t;
    localparam asp_level_t  ASP_LEVEL_RST   = '{rx: 3'h2, tx: 3'h2};

    // DMA request lines of one port.
    typedef struct packed {
        logic tx_burst;
        logic tx_single;
        logic rx_burst;
        logic rx_single;
    } asp_dma_t;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_st_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT}
        asp_rx_st_t;

endpackage

/* asp_serial.sv */
// Dual asynchronous serial port with FIFOs, APB registers and DMA requests.
// Assumes rxd and cts_n are already synchronous to mclk.
//
// Overview of operation
// [RULE1] Two identical ports run independently, each with its own state.
// [RULE2] A software divisor sets the bit rate, reaching at least 3 Mbps.
// [RULE3] Bit timing comes only from dividing mclk, no other clock.
// [RULE4] Each port has a sixteen by eight bit transmit and receive FIFO.
// [RULE5] With the FIFO disabled each direction holds just one character.
// [RULE6] Thresholds of 1/8, 1/4, 1/2, 3/4 and 7/8 can be selected.
// [RULE7] A character has a start bit, five to eight data bits, parity, stop.
// [RULE8] Parity can be even, odd, stick or none, made and checked.
// [RULE9] The transmitter sends one or two stop bits as configured.
// [RULE10] A break can be driven on the line and an incoming one is flagged.
// [RULE11] RTS and CTS throttle each side before further characters go.
// [RULE12] Interrupts fire on FIFO threshold crossing and end of sending.
// [RULE13] Transmit and receive have separate DMA request channels.
// [RULE14] Receive single asks while data is held, burst at the threshold.
// [RULE15] Transmit single asks while space is free, burst at the threshold.
// [RULE16] The line idles high, start low, data LSB first, stop bits high.
// [RULE17] Bits are sampled mid-bit on a 16x tick; a low stop is an error.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ns

module asp_chan
    import asp_pkg::*;
#(
    parameter int DEPTH = ASP_FIFO_DEPTH
)
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        acc,
    input  wire logic        pwrite,
    input  wire logic [3:0]  ridx,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] rdata,
    output logic             bad_addr,
    output logic             txd,
    input  wire logic        rxd,
    input  wire logic        cts_n,
    output logic             rts_n,
    output logic             irq,
    output asp_dma_t         dma
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // Threshold entry count for a level code; eighths of the depth.
    function automatic logic [CW-1:0] lvl_count(input logic [2:0] code);
        int n;
        n = 7;
        case (code)
            3'h0: n = 1;
            3'h1: n = 2;
            3'h2: n = 4;
            3'h3: n = 6;
            default: n = 7;
        endcase
        return CW'((DEPTH * n) / 8);
    endfunction

    // Parity bit for a character under the given mode.
    function automatic logic par_bit(input logic [7:0] d,
                                     input logic [1:0] mode,
                                     input logic       stick);
        logic p;
        p = ^d;
        case (mode)
            ASP_PAR_EVEN: return p;
            ASP_PAR_ODD:  return ~p;
            default:      return stick;
        endcase
    endfunction

    // -------------------------------------------------------------------
    // Register bank
    // -------------------------------------------------------------------
    asp_ctrl_t                ctrl;
    asp_level_t               lvl;
    logic [15:0]              baud_div;
    logic [ASP_NUM_IRQ-1:0]   isr;
    logic [ASP_NUM_IRQ-1:0]   ien;
    logic [ASP_NUM_IRQ-1:0]   set_vec;
    logic                     wr_acc;
    logic                     rd_acc;

    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;

    // Software-written configuration.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl     <= ASP_CTRL_RST;
            lvl      <= ASP_LEVEL_RST;
            baud_div <= ASP_BAUD_RST;
            ien      <= '0;
        end
        else if (wr_acc)
        begin
            unique case (ridx)
                ASP_R_CTRL:  ctrl     <= asp_ctrl_t'(pwdata[ASP_CTRL_W-1:0]);
                ASP_R_BAUD:  baud_div <= pwdata[15:0];  // RULE2
                ASP_R_LEVEL: lvl      <= asp_level_t'(pwdata[5:0]);
                ASP_R_IEN:   ien      <= pwdata[ASP_NUM_IRQ-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status; an event in the clearing cycle survives the clear.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            isr <= '0;
        else if (wr_acc && ridx == ASP_R_ICLR)
            isr <= (isr & ~pwdata[ASP_NUM_IRQ-1:0]) | set_vec;
        else
            isr <= isr | set_vec;
    end

    assign irq = |(isr & ien);  // RULE12

    // -------------------------------------------------------------------
    // Baud tick: one pulse per (divisor + 1) clocks, sixteen per bit.
    // -------------------------------------------------------------------
    logic [15:0] div_cnt;
    logic        tick;

    assign tick = (div_cnt == baud_div);  // RULE3

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            div_cnt <= '0;
        else if (tick || !ctrl.enable)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 16'h0001;
    end

    // -------------------------------------------------------------------
    // FIFOs
    // -------------------------------------------------------------------
    logic [7:0]    tx_mem [DEPTH];
    logic [7:0]    rx_mem [DEPTH];
    logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [CW-1:0] tx_cnt, rx_cnt, lim, rx_thr, tx_thr;
    logic          tx_push, tx_pop, rx_push, rx_pop;
    logic          tx_full, rx_full;
    logic [7:0]    rx_char;

    // Depth one gives the plain double-buffered behaviour.
    assign lim     = ctrl.fifo_en ? CW'(DEPTH) : CW'(1);  // RULE5
    assign tx_full = (tx_cnt >= lim);  // RULE4
    assign rx_full = (rx_cnt >= lim);
    assign tx_push = wr_acc && ridx == ASP_R_DATA && !tx_full;
    assign rx_pop  = rd_acc && ridx == ASP_R_DATA && rx_cnt != '0;
    assign rx_thr  = ctrl.fifo_en ? lvl_count(lvl.rx) : CW'(1);  // RULE6
    assign tx_thr  = ctrl.fifo_en ? lvl_count(lvl.tx) : CW'(0);

    // Transmit queue; a write while full is dropped.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= '0;
        end
        else
        begin
            if (tx_push)
                tx_wp <= tx_wp + AW'(1);
            if (tx_pop)
                tx_rp <= tx_rp + AW'(1);
            tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
        end
    end

    // Receive queue pointers.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_wp  <= '0;
            rx_rp  <= '0;
            rx_cnt <= '0;
        end
        else
        begin
            if (rx_push)
                rx_wp <= rx_wp + AW'(1);
            if (rx_pop)
                rx_rp <= rx_rp + AW'(1);
            rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
        end
    end

    // Storage has no reset; only the pointers decide what is valid.
    always_ff @(posedge mclk)
    begin
        if (tx_push)
            tx_mem[tx_wp] <= pwdata[7:0];
        if (rx_push)
            rx_mem[rx_wp] <= rx_char;
    end

    // -------------------------------------------------------------------
    // Transmitter
    // -------------------------------------------------------------------
    asp_tx_st_t tx_st;
    logic [3:0] tx_sub;
    logic [2:0] tx_idx;
    logic [7:0] tx_sh;
    logic       tx_par, tx_stop2, tx_bit_end, cts_ok, tx_last;
    logic [2:0] last_idx;

    assign last_idx   = 3'h4 + {1'b0, ctrl.wlen};  // RULE7
    assign tx_bit_end = tick && tx_sub == 4'hf;
    assign cts_ok     = !ctrl.cts_flow || !cts_n;  // RULE11
    assign tx_pop     = tx_st == TX_IDLE && ctrl.enable && tx_cnt != '0
                        && cts_ok;
    assign tx_last    = tx_st == TX_STOP && tx_bit_end
                        && (!ctrl.two_stop || tx_stop2);

    // Frame sequencer; a new character starts only when CTS allows.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            tx_st    <= TX_IDLE;
            tx_sub   <= '0;
            tx_idx   <= '0;
            tx_sh    <= '0;
            tx_par   <= 1'b0;
            tx_stop2 <= 1'b0;
        end
        else
        begin
            if (tx_st == TX_IDLE)
                tx_sub <= '0;
            else if (tick)
                tx_sub <= tx_sub + 4'h1;
            unique case (tx_st)
                TX_IDLE:
                    if (tx_pop)
                    begin
                        tx_sh    <= tx_mem[tx_rp];
                        tx_par   <= par_bit(tx_mem[tx_rp] &
                                            (8'hff >> (3'h3 - ctrl.wlen)),
                                            ctrl.parity, ctrl.stick_val);
                        tx_st    <= TX_START;
                        tx_idx   <= '0;
                        tx_stop2 <= 1'b0;
                    end
                TX_START:
                    if (tx_bit_end)
                        tx_st <= TX_DATA;
                TX_DATA:
                    if (tx_bit_end)
                    begin
                        tx_sh  <= tx_sh >> 1;  // RULE16
                        tx_idx <= tx_idx + 3'h1;
                        if (tx_idx == last_idx)
                            tx_st <= (ctrl.parity == ASP_PAR_NONE) ?
                                     TX_STOP : TX_PAR;
                    end
                TX_PAR:
                    if (tx_bit_end)
                        tx_st <= TX_STOP;
                TX_STOP:
                    if (tx_last)
                        tx_st <= TX_IDLE;
                    else if (tx_bit_end)
                        tx_stop2 <= 1'b1;  // RULE9
            endcase
        end
    end

    // Registered line level, so the pin never glitches; break forces low.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            txd <= 1'b1;
        else if (ctrl.send_break)
            txd <= 1'b0;  // RULE10
        else
        begin
            unique case (tx_st)
                TX_START: txd <= 1'b0;
                TX_DATA:  txd <= tx_sh[0];
                TX_PAR:   txd <= tx_par;  // RULE8
                default:  txd <= 1'b1;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Receiver
    // -------------------------------------------------------------------
    asp_rx_st_t rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_idx;
    logic       rx_par, rx_ones, rx_mid, stop_seen, is_break;

    assign rx_mid    = tick && rx_sub == 4'hf;
    assign stop_seen = rx_st == RX_STOP && rx_mid;
    assign is_break  = stop_seen && !rxd && !rx_ones;
    assign rx_push   = stop_seen && !is_break && !rx_full;

    // The start edge is confirmed at half a bit, then each bit is taken
    // sixteen ticks later, near its centre.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_st   <= RX_IDLE;
            rx_sub  <= '0;
            rx_idx  <= '0;
            rx_char <= '0;
            rx_par  <= 1'b0;
            rx_ones <= 1'b0;
        end
        else
        begin
            if (rx_st == RX_IDLE || rx_st == RX_WAIT)
                rx_sub <= '0;
            else if (rx_st == RX_START && tick && rx_sub == 4'h7)
                rx_sub <= '0;
            else if (tick)
                rx_sub <= rx_sub + 4'h1;
            unique case (rx_st)
                RX_IDLE:
                    if (ctrl.enable && !rxd)
                    begin
                        rx_st   <= RX_START;
                        rx_idx  <= '0;
                        rx_char <= '0;
                        rx_ones <= 1'b0;
                    end
                RX_START:
                    if (tick && rx_sub == 4'h7)
                        rx_st <= rxd ? RX_IDLE : RX_DATA;  // RULE17
                RX_DATA:
                    if (rx_mid)
                    begin
                        rx_char[rx_idx] <= rxd;  // RULE16
                        rx_ones         <= rx_ones | rxd;
                        rx_idx          <= rx_idx + 3'h1;
                        if (rx_idx == last_idx)
                            rx_st <= (ctrl.parity == ASP_PAR_NONE) ?
                                     RX_STOP : RX_PAR;
                    end
                RX_PAR:
                    if (rx_mid)
                    begin
                        rx_par  <= rxd;
                        rx_ones <= rx_ones | rxd;
                        rx_st   <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_mid)
                        rx_st <= rxd ? RX_IDLE : RX_WAIT;
                RX_WAIT:
                    if (rxd)
                        rx_st <= RX_IDLE;  // Line must return high first.
            endcase
        end
    end

    // Request-to-send is withdrawn while the receive queue is full.
    assign rts_n = ctrl.rts_flow && rx_full;  // RULE11

    // -------------------------------------------------------------------
    // Events and DMA requests
    // -------------------------------------------------------------------
    logic rx_hit, tx_hit, rx_hit_q, tx_hit_q, par_err;

    assign rx_hit  = rx_cnt >= rx_thr;
    assign tx_hit  = tx_cnt <= tx_thr;
    assign par_err = stop_seen && !is_break && ctrl.parity != ASP_PAR_NONE
                     && rx_par != par_bit(rx_char, ctrl.parity,
                                          ctrl.stick_val);

    // Previous threshold state, so only crossings raise the level flags.
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_hit_q <= 1'b0;
            tx_hit_q <= 1'b1;
        end
        else
        begin
            rx_hit_q <= rx_hit;
            tx_hit_q <= tx_hit;
        end
    end

    always_comb
    begin
        set_vec                = '0;
        set_vec[ASP_I_RXLVL]   = rx_hit && !rx_hit_q;  // RULE12
        set_vec[ASP_I_TXLVL]   = tx_hit && !tx_hit_q;  // RULE12
        set_vec[ASP_I_EOT]     = tx_last && tx_cnt == '0;  // RULE12
        set_vec[ASP_I_FRAME]   = stop_seen && !rxd;  // RULE17
        set_vec[ASP_I_PARITY]  = par_err;  // RULE8
        set_vec[ASP_I_BREAK]   = is_break;  // RULE10
        set_vec[ASP_I_OVERRUN] = stop_seen && !is_break && rx_full;
    end

    // Separate receive and transmit request channels.
    assign dma.rx_single = rx_cnt != '0;  // RULE14
    assign dma.rx_burst  = rx_hit;  // RULE14
    assign dma.tx_single = !tx_full;  // RULE15
    assign dma.tx_burst  = tx_hit;  // RULE15

    // -------------------------------------------------------------------
    // Read mux; the data register reads the oldest received character.
    // -------------------------------------------------------------------
    always_comb
    begin
        rdata    = '0;
        bad_addr = 1'b0;
        unique case (ridx)
            ASP_R_DATA:   rdata[7:0] = (rx_cnt != '0) ? rx_mem[rx_rp] : 8'h00;
            ASP_R_CTRL:   rdata[ASP_CTRL_W-1:0] = ctrl;
            ASP_R_BAUD:   rdata[15:0] = baud_div;
            ASP_R_LEVEL:  rdata[5:0] = lvl;
            ASP_R_STATUS: rdata = {8'h00, 3'h0, rx_cnt, 3'h0, tx_cnt,
                                   2'h0, cts_n, tx_st != TX_IDLE,
                                   rx_cnt == '0, rx_full,
                                   tx_cnt == '0, tx_full};
            ASP_R_ISR:    rdata[ASP_NUM_IRQ-1:0] = isr;
            ASP_R_IEN:    rdata[ASP_NUM_IRQ-1:0] = ien;
            ASP_R_ICLR:   rdata = '0;
            default:      bad_addr = 1'b1;
        endcase
    end
endmodule

module asp_serial
    import asp_pkg::*;
#(
    parameter int DEPTH = ASP_FIFO_DEPTH
)
(
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic [7:0]               paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    output logic      [ASP_NUM_PORTS-1:0] txd,
    input  wire logic [ASP_NUM_PORTS-1:0] rxd,
    input  wire logic [ASP_NUM_PORTS-1:0] cts_n,
    output logic      [ASP_NUM_PORTS-1:0] rts_n,
    output logic      [ASP_NUM_PORTS-1:0] irq,
    output asp_dma_t  [ASP_NUM_PORTS-1:0] dma
);
    logic [31:0] rd_port [ASP_NUM_PORTS];
    logic        bad     [ASP_NUM_PORTS];
    logic        sel_hi;
    logic        legal;

    // Every access finishes in its first access cycle.
    assign pready = 1'b1;
    assign sel_hi = paddr[ASP_PORT_BIT];
    // Bit 7 and the two low bits must be clear for a real register access.
    assign legal  = !paddr[7] && paddr[1:0] == 2'h0;

    // Two independent copies; bit 6 of the address picks one.
    for (genvar i = 0; i < ASP_NUM_PORTS; i++)
    begin : g_port
        asp_chan #(
            .DEPTH (DEPTH)
        ) u_chan (
            .mclk     (mclk),
            .resetn   (resetn),
            .acc      (psel && penable && legal && sel_hi == 1'(i)),  // RULE1
            .pwrite   (pwrite),
            .ridx     (paddr[5:2]),
            .pwdata   (pwdata),
            .rdata    (rd_port[i]),
            .bad_addr (bad[i]),
            .txd      (txd[i]),
            .rxd      (rxd[i]),
            .cts_n    (cts_n[i]),
            .rts_n    (rts_n[i]),
            .irq      (irq[i]),
            .dma      (dma[i])  // RULE13
        );
    end

    // Unmapped words and misaligned addresses answer with an error, read
    // zero and reach no register, so a stray read cannot pop a character.
    assign prdata  = legal ? rd_port[sel_hi] : 32'h0;
    assign pslverr = psel && penable && (bad[sel_hi] || !legal);
endmodule

/* asp_serial_monitor.sv */
// Checker of the dual serial port, seeing only the ports of asp_serial.
// Assumes port 0 carries the serial traffic; any divisor value.
`timescale 1ns/1ns
module asp_serial_mon
    import asp_pkg::*;
(
    input wire logic                     mclk,
    input wire logic                     resetn,
    input wire logic [7:0]               paddr,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic [ASP_NUM_PORTS-1:0] txd,
    input wire logic [ASP_NUM_PORTS-1:0] rxd,
    input wire logic [ASP_NUM_PORTS-1:0] cts_n,
    input wire logic [ASP_NUM_PORTS-1:0] rts_n,
    input wire logic [ASP_NUM_PORTS-1:0] irq,
    input wire asp_dma_t [ASP_NUM_PORTS-1:0] dma
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // A bit is 16 ticks of at least one clock, so any run spans 8 clocks.
    a_start_low: assert property ($fell(txd[0]) |-> !txd[0] [*8])
        else $error("txd low run too short");
    a_stop_high: assert property ($rose(txd[0]) |-> txd[0] [*8])
        else $error("txd high run too short");
    a_tx_burst: assert property (dma[0].tx_burst |-> dma[0].tx_single)
        else $error("tx burst without free entry");
    a_rx_burst: assert property (dma[0].rx_burst |-> dma[0].rx_single)
        else $error("rx burst without data");
    a_rts_full: assert property (rts_n[0] |-> dma[0].rx_single
        && dma[0].rx_burst)
        else $error("rts raised while rx not full");
    a_bad_addr: assert property (psel && penable && paddr[7] |-> pslverr)
        else $error("no error on unmapped address");
    a_err_data: assert property (psel && penable && pslverr
        |-> prdata == 32'h0)
        else $error("read data not zero on error");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("wait state inserted");
    c_rts: cover property (rts_n[0]);
    c_tx: cover property ($fell(txd[0]));
    c_err: cover property (psel && penable && pslverr);
endmodule
bind asp_serial asp_serial_mon asp_serial_mon_i (.mclk(mclk),
    .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd(txd), .rxd(rxd), .cts_n(cts_n),
    .rts_n(rts_n), .irq(irq), .dma(dma));

/* async_serial_port_fifo_test.sv */
// Self-checking bench of the dual serial port over APB.
// Assumes the checker is bound in; port 1 line inputs idle.
`timescale 1ns/1ns
module async_serial_port_fifo_test;
    import asp_pkg::*;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] txd, rxd, cts_n, rts_n, irq;
    asp_dma_t [1:0] dma;
    int n_fail, checks, cyc;
    asp_serial asp_serial_i (.mclk(mclk), .resetn(resetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
        .rxd(rxd), .cts_n(cts_n), .rts_n(rts_n), .irq(irq), .dma(dma));
    asp_peer asp_peer_i (.mclk(mclk), .txd(txd[0]), .rxd(rxd[0]),
        .cts_n(cts_n[0]));
    assign rxd[1] = 1'b1;
    assign cts_n[1] = 1'b0;
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        checks++;
        if (e !== g)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // Read data is taken at the completing edge; the task returns half a
    // cycle later, once that edge's register updates have settled.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(negedge mclk);
    endtask
    // A hang ends the run as a failure.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    initial
    begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {n_fail, checks, cyc} = '0;
        void'($urandom(32'h264aceec));
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        chk("dma", 32'hc, 32'(dma[0]));
        apb(0, 8'h04, 0); chk("ctrl", 32'h100, rd);
        apb(0, 8'h08, 0); chk("baud", 32'h1a, rd);
        apb(0, 8'h0c, 0); chk("level", 32'h12, rd);
        apb(0, 8'h20, 0); chk("slverr", 1, 32'(er));
        apb(1, 8'h08, 0);
        apb(1, 8'h18, 4);
        apb(1, 8'h04, 32'h107);
        apb(0, 8'h44, 0); chk("ctrl1", 32'h100, rd);
        b = 8'($urandom);
        apb(1, 8'h00, 32'(b));
        for (int k = 0; k < 400 && !asp_peer_i.got; k++) @(posedge mclk);
        chk("tx char", 32'(b), 32'(asp_peer_i.rx_byte));
        for (int k = 0; k < 100 && irq[0] !== 1'b1; k++) @(posedge mclk);
        chk("eot irq", 1, 32'(irq[0]));
        apb(1, 8'h1c, 4);
        chk("irq clr", 0, 32'(irq[0]));
        apb(1, 8'h04, 32'h407);
        b = 8'($urandom);
        asp_peer_i.send(b);
        chk("rts", 1, 32'(rts_n[0]));
        chk("rx dma", 1, 32'(dma[0].rx_single));
        apb(0, 8'h00, 0); chk("rx char", 32'(b), rd);
        chk("rts off", 0, 32'(rts_n[0]));
        chk("port1", 32'h62, 32'({dma[1], irq[1], txd[1], rts_n[1]}));
        give_verdict();
    end
endmodule
